// ===== core/edmalu_pkg.sv
package edmalu_pkg;

    // ----------------------------------------------------------------
    // Operation codes presented by the decoder
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        EDMALU_OP_DEC_TO_ACC        = 4'h0,
        EDMALU_OP_INC_IN_MEM        = 4'h1,
        EDMALU_OP_INC_TO_ACC        = 4'h2,
        EDMALU_OP_MOVE_MEM_TO_ACC   = 4'h3,
        EDMALU_OP_MOVE_ACC_TO_MEM   = 4'h4,
        EDMALU_OP_OR_TO_ACC         = 4'h5,
        EDMALU_OP_OR_TO_MEM         = 4'h6,
        EDMALU_OP_ROTL_IN_MEM       = 4'h7,
        EDMALU_OP_ROTL_TO_ACC       = 4'h8,
        EDMALU_OP_ROTL_CARRY_IN_MEM = 4'h9,
        EDMALU_OP_ROTL_CARRY_TO_ACC = 4'hA,
        EDMALU_OP_ROTR_IN_MEM       = 4'hB
    } edmalu_op_t;

    // ----------------------------------------------------------------
    // Widths, field positions and reset values
    // ----------------------------------------------------------------
    localparam int         DATA_W    = 8;
    localparam int         ADDR_W    = 16;
    localparam int         MSB_POS   = 7;
    localparam int         LSB_POS   = 0;
    localparam logic [7:0] ONE       = 8'h01;
    localparam logic [7:0] ACC_RST   = 8'h00;
    localparam logic       FLAG_RST  = 1'b0;

endpackage

// ===== core/edmalu_exec.sv
`timescale 1ns/1ns
// Combinational result unit: computes the result byte, its destination,
// and the flag effects of one operation.
module edmalu_exec (
    input  wire edmalu_pkg::edmalu_op_t op_i,
    input  wire logic [7:0]             acc_i,
    input  wire logic [7:0]             mem_i,
    input  wire logic                   carry_i,
    output logic [7:0]                  result_o,
    output logic                        to_acc_o,
    output logic                        to_mem_o,
    output logic                        z_upd_o,
    output logic                        c_upd_o,
    output logic                        c_val_o
);

    // ----------------------------------------------------------------
    // Result selection
    // ----------------------------------------------------------------
    // Byte arithmetic is cut to eight bits, so it wraps modulo 256.
    wire logic [7:0] inc_w  = 8'(mem_i + edmalu_pkg::ONE);
    wire logic [7:0] dec_w  = 8'(mem_i - edmalu_pkg::ONE);
    wire logic [7:0] or_w   = acc_i | mem_i;
    wire logic [7:0] rotl_w = {mem_i[6:0], mem_i[edmalu_pkg::MSB_POS]};
    wire logic [7:0] rlc_w  = {mem_i[6:0], carry_i};
    wire logic [7:0] rotr_w = {mem_i[edmalu_pkg::LSB_POS], mem_i[7:1]};

    // One case picks result, destination and flag effect together.
    always_comb begin
        result_o = mem_i;
        to_acc_o = 1'b0;
        to_mem_o = 1'b0;
        z_upd_o  = 1'b0;
        c_upd_o  = 1'b0;
        c_val_o  = mem_i[edmalu_pkg::MSB_POS];
        unique case (op_i)
            edmalu_pkg::EDMALU_OP_DEC_TO_ACC: begin
                result_o = dec_w;
                to_acc_o = 1'b1;
                z_upd_o  = 1'b1;
            end
            edmalu_pkg::EDMALU_OP_INC_IN_MEM: begin
                result_o = inc_w;
                to_mem_o = 1'b1;
                z_upd_o  = 1'b1;
            end
            edmalu_pkg::EDMALU_OP_INC_TO_ACC: begin
                result_o = inc_w;
                to_acc_o = 1'b1;
                z_upd_o  = 1'b1;
            end
            edmalu_pkg::EDMALU_OP_MOVE_MEM_TO_ACC: begin
                result_o = mem_i;
                to_acc_o = 1'b1;
            end
            edmalu_pkg::EDMALU_OP_MOVE_ACC_TO_MEM: begin
                result_o = acc_i;
                to_mem_o = 1'b1;
            end
            edmalu_pkg::EDMALU_OP_OR_TO_ACC: begin
                result_o = or_w;
                to_acc_o = 1'b1;
                z_upd_o  = 1'b1;
            end
            edmalu_pkg::EDMALU_OP_OR_TO_MEM: begin
                result_o = or_w;
                to_mem_o = 1'b1;
                z_upd_o  = 1'b1;
            end
            edmalu_pkg::EDMALU_OP_ROTL_IN_MEM: begin
                result_o = rotl_w;
                to_mem_o = 1'b1;
            end
            edmalu_pkg::EDMALU_OP_ROTL_TO_ACC: begin
                result_o = rotl_w;
                to_acc_o = 1'b1;
            end
            edmalu_pkg::EDMALU_OP_ROTL_CARRY_IN_MEM: begin
                result_o = rlc_w;
                to_mem_o = 1'b1;
                c_upd_o  = 1'b1;
            end
            edmalu_pkg::EDMALU_OP_ROTL_CARRY_TO_ACC: begin
                result_o = rlc_w;
                to_acc_o = 1'b1;
                c_upd_o  = 1'b1;
            end
            edmalu_pkg::EDMALU_OP_ROTR_IN_MEM: begin
                result_o = rotr_w;
                to_mem_o = 1'b1;
            end
            default: begin
                // Codes 12 to 15 are illegal and change nothing.
                result_o = mem_i;
            end
        endcase
    end

endmodule

// ===== core/edmalu_top.sv
`timescale 1ns/1ns
module edmalu_top (
    input  wire logic                   clk_i,
    input  wire logic                   reset_i,
    input  wire logic                   start_i,
    input  wire edmalu_pkg::edmalu_op_t op_i,
    input  wire logic [15:0]            addr_i,
    input  wire logic [7:0]             mem_rdata_i,
    output logic [15:0]                 mem_addr_o,
    output logic                        mem_we_o,
    output logic [7:0]                  mem_wdata_o,
    output logic [7:0]                  acc_o,
    output logic                        zero_o,
    output logic                        carry_o,
    output logic                        busy_o,
    output logic                        done_o
);

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    // Memory is synchronous: the address goes out in READ, the byte is
    // valid in EXEC, and a write goes out in the same EXEC edge.
    typedef enum logic [1:0] {EDMALU_IDLE, EDMALU_READ, EDMALU_EXEC} edmalu_state_t;

    edmalu_state_t          state_reg;
    edmalu_state_t          state_next;
    edmalu_pkg::edmalu_op_t op_reg;
    logic [15:0]            addr_reg;
    logic [7:0]             acc_reg;
    logic                   zero_reg;
    logic                   carry_reg;
    logic                   we_reg;
    logic [7:0]             wdata_reg;
    logic                   done_reg;
    logic                   busy_reg;

    wire logic [7:0] result_w;
    wire logic       to_acc_w;
    wire logic       to_mem_w;
    wire logic       z_upd_w;
    wire logic       c_upd_w;
    wire logic       c_val_w;

    edmalu_exec u_exec (
        .op_i     (op_reg),
        .acc_i    (acc_reg),
        .mem_i    (mem_rdata_i),
        .carry_i  (carry_reg),
        .result_o (result_w),
        .to_acc_o (to_acc_w),
        .to_mem_o (to_mem_w),
        .z_upd_o  (z_upd_w),
        .c_upd_o  (c_upd_w),
        .c_val_o  (c_val_w)
    );

    // Step decode as named wires. Gating the accept with busy_reg also
    // refuses a start in the done cycle, when the state is already idle.
    wire logic exec_w   = (state_reg == EDMALU_EXEC);
    wire logic accept_w = !busy_reg && start_i;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            EDMALU_IDLE: if (accept_w) state_next = EDMALU_READ;
            EDMALU_READ: state_next = EDMALU_EXEC;
            EDMALU_EXEC: state_next = EDMALU_IDLE;
        endcase
    end

    // State and operand capture; a start while busy is ignored.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_reg <= EDMALU_IDLE;
            op_reg    <= edmalu_pkg::EDMALU_OP_MOVE_MEM_TO_ACC;
            addr_reg  <= 16'h0000;
            busy_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            busy_reg  <= accept_w || (state_reg != EDMALU_IDLE);
            if (accept_w) begin
                op_reg   <= op_i;
                addr_reg <= addr_i;
            end
        end
    end

    // ----------------------------------------------------------------
    // Architectural state and memory write
    // ----------------------------------------------------------------
    // Flags change only when the operation says so; all others hold.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            acc_reg   <= edmalu_pkg::ACC_RST;
            zero_reg  <= edmalu_pkg::FLAG_RST;
            carry_reg <= edmalu_pkg::FLAG_RST;
            we_reg    <= 1'b0;
            wdata_reg <= 8'h00;
            done_reg  <= 1'b0;
        end else begin
            we_reg   <= exec_w && to_mem_w;
            done_reg <= exec_w;
            if (exec_w && to_mem_w) wdata_reg <= result_w;
            if (exec_w && to_acc_w) acc_reg <= result_w;
            if (exec_w && z_upd_w) zero_reg <= (result_w == 8'h00);
            if (exec_w && c_upd_w) carry_reg <= c_val_w;
        end
    end

    assign mem_addr_o  = addr_reg;
    assign mem_we_o    = we_reg;
    assign mem_wdata_o = wdata_reg;
    assign acc_o       = acc_reg;
    assign zero_o      = zero_reg;
    assign carry_o     = carry_reg;
    assign busy_o      = busy_reg;
    assign done_o      = done_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // All but the last two checks fire at the EXEC edge and look one edge later, when the
    // registered results are visible and $past still holds the read byte.
    sequence s_exec_op(edmalu_pkg::edmalu_op_t o);
        exec_w && (op_reg == o);
    endsequence

    // After the accept the operation passes READ, then EXEC, then done.
    sequence s_finish;
        ##1 exec_w ##1 done_o;
    endsequence

    // Operations that load the accumulator and also update the zero flag.
    wire logic zero_acc_op_w = (op_reg == edmalu_pkg::EDMALU_OP_DEC_TO_ACC)
                            || (op_reg == edmalu_pkg::EDMALU_OP_INC_TO_ACC)
                            || (op_reg == edmalu_pkg::EDMALU_OP_OR_TO_ACC);

    // Only the two carry rotates may touch the carry flag.
    wire logic carry_op_w = (op_reg == edmalu_pkg::EDMALU_OP_ROTL_CARRY_IN_MEM)
                         || (op_reg == edmalu_pkg::EDMALU_OP_ROTL_CARRY_TO_ACC);

    chk_dec_acc_value: assert property (@(posedge clk_i) disable iff (reset_i)
        s_exec_op(edmalu_pkg::EDMALU_OP_DEC_TO_ACC) |=> (acc_reg == 8'($past(mem_rdata_i) - 8'h01))
            && !mem_we_o && $stable(carry_reg))
        else $error("decrement to accumulator result wrong");

    chk_inc_mem_write: assert property (@(posedge clk_i) disable iff (reset_i)
        s_exec_op(edmalu_pkg::EDMALU_OP_INC_IN_MEM) |=> mem_we_o
            && (mem_wdata_o == 8'($past(mem_rdata_i) + 8'h01)) && $stable(acc_reg))
        else $error("increment in memory write wrong");

    chk_inc_acc_value: assert property (@(posedge clk_i) disable iff (reset_i)
        s_exec_op(edmalu_pkg::EDMALU_OP_INC_TO_ACC) |=> (acc_reg == 8'($past(mem_rdata_i) + 8'h01))
            && !mem_we_o)
        else $error("increment to accumulator result wrong");

    chk_move_no_flags: assert property (@(posedge clk_i) disable iff (reset_i)
        s_exec_op(edmalu_pkg::EDMALU_OP_MOVE_MEM_TO_ACC) |=> (acc_reg == $past(mem_rdata_i))
            && $stable(zero_reg) && $stable(carry_reg))
        else $error("move to accumulator wrong or flags changed");

    chk_store_acc: assert property (@(posedge clk_i) disable iff (reset_i)
        s_exec_op(edmalu_pkg::EDMALU_OP_MOVE_ACC_TO_MEM) |=> mem_we_o
            && (mem_wdata_o == acc_reg) && $stable(zero_reg))
        else $error("move to memory wrong");

    chk_or_acc_zero: assert property (@(posedge clk_i) disable iff (reset_i)
        s_exec_op(edmalu_pkg::EDMALU_OP_OR_TO_ACC) |=> (acc_reg == ($past(acc_reg)
            | $past(mem_rdata_i))) && (zero_reg == (acc_reg == 8'h00)))
        else $error("or to accumulator wrong");

    chk_or_mem_write: assert property (@(posedge clk_i) disable iff (reset_i)
        s_exec_op(edmalu_pkg::EDMALU_OP_OR_TO_MEM) |=> mem_we_o
            && (zero_reg == (mem_wdata_o == 8'h00)) && $stable(acc_reg))
        else $error("or to memory wrong");

    chk_rotl_mem: assert property (@(posedge clk_i) disable iff (reset_i)
        s_exec_op(edmalu_pkg::EDMALU_OP_ROTL_IN_MEM) |=> mem_we_o
            && (mem_wdata_o == {$past(mem_rdata_i[6:0]), $past(mem_rdata_i[7])}))
        else $error("rotate left in memory wrong");

    chk_rotl_acc: assert property (@(posedge clk_i) disable iff (reset_i)
        s_exec_op(edmalu_pkg::EDMALU_OP_ROTL_TO_ACC) |=>
            (acc_reg == {$past(mem_rdata_i[6:0]), $past(mem_rdata_i[7])}) && !mem_we_o)
        else $error("rotate left to accumulator wrong");

    chk_rlc_mem: assert property (@(posedge clk_i) disable iff (reset_i)
        s_exec_op(edmalu_pkg::EDMALU_OP_ROTL_CARRY_IN_MEM) |=>
            (mem_wdata_o == {$past(mem_rdata_i[6:0]), $past(carry_reg)})
            && (carry_reg == $past(mem_rdata_i[7])))
        else $error("rotate through carry in memory wrong");

    chk_rlc_acc: assert property (@(posedge clk_i) disable iff (reset_i)
        s_exec_op(edmalu_pkg::EDMALU_OP_ROTL_CARRY_TO_ACC) |=>
            (acc_reg == {$past(mem_rdata_i[6:0]), $past(carry_reg)})
            && (carry_reg == $past(mem_rdata_i[7])) && !mem_we_o)
        else $error("rotate through carry to accumulator wrong");

    chk_rotr_mem: assert property (@(posedge clk_i) disable iff (reset_i)
        s_exec_op(edmalu_pkg::EDMALU_OP_ROTR_IN_MEM) |=> mem_we_o
            && (mem_wdata_o == {$past(mem_rdata_i[0]), $past(mem_rdata_i[7:1])}))
        else $error("rotate right in memory wrong");

    chk_zero_acc_ops: assert property (@(posedge clk_i) disable iff (reset_i)
        exec_w && zero_acc_op_w |=> (zero_reg == (acc_reg == 8'h00)))
        else $error("zero flag does not follow the new accumulator");

    chk_zero_inc_mem: assert property (@(posedge clk_i) disable iff (reset_i)
        s_exec_op(edmalu_pkg::EDMALU_OP_INC_IN_MEM) |=> (zero_reg == (mem_wdata_o == 8'h00)))
        else $error("zero flag does not follow the incremented byte");

    chk_carry_held: assert property (@(posedge clk_i) disable iff (reset_i)
        exec_w && !carry_op_w |=> $stable(carry_reg))
        else $error("carry changed by an operation that must keep it");

    // A refused request must leave the captured address and code alone.
    chk_start_refused: assert property (@(posedge clk_i) disable iff (reset_i)
        busy_o && start_i |=> $stable(mem_addr_o) && $stable(op_reg))
        else $error("request taken while busy");

    chk_done_timing: assert property (@(posedge clk_i) disable iff (reset_i)
        accept_w |=> s_finish)
        else $error("operation did not finish in three cycles");

endmodule

// ===== verif/edmalu_top_tb_top.sv
`timescale 1ns/1ns
module edmalu_top_tb_top;

    // ------------------------------------------------------------
    // Stimulus, observed outputs and expected state
    // ------------------------------------------------------------
    logic                   clk_i;
    logic                   reset_i;
    logic                   start_i;
    edmalu_pkg::edmalu_op_t op_i;
    logic [15:0]            addr_i;
    logic [7:0]             mem_rdata_i;
    logic [15:0]            mem_addr_o;
    logic                   mem_we_o;
    logic [7:0]             mem_wdata_o;
    logic [7:0]             acc_o;
    logic                   zero_o;
    logic                   carry_o;
    logic                   busy_o;
    logic                   done_o;
    int                     error_cnt;
    int                     samples_checked;
    logic [7:0]             exp_acc;
    logic                   exp_z;
    logic                   exp_c;

    edmalu_top i_edmalu_top (
        .clk_i       (clk_i),
        .reset_i     (reset_i),
        .start_i     (start_i),
        .op_i        (op_i),
        .addr_i      (addr_i),
        .mem_rdata_i (mem_rdata_i),
        .mem_addr_o  (mem_addr_o),
        .mem_we_o    (mem_we_o),
        .mem_wdata_o (mem_wdata_o),
        .acc_o       (acc_o),
        .zero_o      (zero_o),
        .carry_o     (carry_o),
        .busy_o      (busy_o),
        .done_o      (done_o)
    );

    // A half period of 25 ns gives the 20 MHz core clock.
    always #25 clk_i = ~clk_i;

    // ------------------------------------------------------------
    // Compare, closing and bus tasks
    // ------------------------------------------------------------
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t ns: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic do_reset();
        reset_i = 1'b1;
        repeat (6) @(posedge clk_i);
        #1;
        reset_i = 1'b0;
        exp_acc = 8'h00;
        exp_z = 1'b0;
        exp_c = 1'b0;
    endtask

    // One full operation. Codes follow the package's enumeration order.
    // The memory line shows the inverted byte outside the EXEC cycle, so a
    // sample taken in the wrong cycle cannot pass by accident. With poke set
    // a second request stands from the read cycle through the done cycle,
    // while busy is high, and must be ignored.
    task automatic exec_op(input logic [3:0] code, input logic [15:0] a,
                           input logic [7:0] b, input bit poke);
        logic [7:0] res;
        logic       tm;
        logic       ta;
        logic       zu;
        case (code)
            4'h0: res = b - 8'h01;
            4'h1, 4'h2: res = b + 8'h01;
            4'h4: res = exp_acc;
            4'h5, 4'h6: res = exp_acc | b;
            4'h7, 4'h8: res = {b[6:0], b[7]};
            4'h9, 4'hA: res = {b[6:0], exp_c};
            4'hB: res = {b[0], b[7:1]};
            default: res = b;
        endcase
        tm = code inside {4'h1, 4'h4, 4'h6, 4'h7, 4'h9, 4'hB};
        ta = code inside {4'h0, 4'h2, 4'h3, 4'h5, 4'h8, 4'hA};
        zu = code inside {4'h0, 4'h1, 4'h2, 4'h5, 4'h6};
        start_i = 1'b1;
        op_i = edmalu_pkg::edmalu_op_t'(code);
        addr_i = a;
        mem_rdata_i = ~b;
        @(posedge clk_i);
        #1;
        start_i = poke;
        op_i = edmalu_pkg::edmalu_op_t'(4'h4);
        addr_i = ~a;
        chk_bit(busy_o, 1'b1, "busy in read");
        chk_bit(done_o, 1'b0, "done too early");
        @(posedge clk_i);
        #1;
        mem_rdata_i = b;
        chk_bit(mem_we_o, 1'b0, "write too early");
        @(posedge clk_i);
        #1;
        mem_rdata_i = ~b;
        if (ta) exp_acc = res;
        if (zu) exp_z = (res == 8'h00);
        if (code == 4'h9 || code == 4'hA) exp_c = b[7];
        chk_bit(done_o, 1'b1, "done");
        chk_bit(mem_we_o, tm, "write strobe");
        if (tm) chk_val(mem_wdata_o, res, "write data");
        chk_val(mem_addr_o, a, "address");
        chk_val(acc_o, exp_acc, "accumulator");
        chk_bit(zero_o, exp_z, "zero flag");
        chk_bit(carry_o, exp_c, "carry flag");
        @(posedge clk_i);
        #1;
        chk_bit(done_o | mem_we_o | busy_o, 1'b0, "idle after done");
        if (poke) begin
            chk_val(mem_addr_o, a, "address after refused request");
            start_i = 1'b0;
            @(posedge clk_i);
            #1;
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk_val(acc_o, 8'h00, "reset acc");
        chk_val(mem_addr_o, 16'h0000, "reset address");
        chk_val(mem_wdata_o, 8'h00, "reset write data");
        chk_bit(zero_o | carry_o | busy_o | done_o | mem_we_o, 1'b0, "reset flags");
        $display("Test reset finished");
    endtask

    task automatic t_inc_dec();
        exec_op(4'h2, 16'h0010, 8'hFF, 1'b0);
        exec_op(4'h0, 16'h0011, 8'h01, 1'b0);
        exec_op(4'h0, 16'h0012, 8'h00, 1'b0);
        exec_op(4'h1, 16'hFFFF, 8'h7F, 1'b0);
        exec_op(4'h1, 16'h8000, 8'hFF, 1'b0);
        $display("Test increment and decrement finished");
    endtask

    task automatic t_move();
        exec_op(4'h3, 16'h1234, 8'h5A, 1'b0);
        exec_op(4'h4, 16'h4321, 8'hC3, 1'b1);
        exec_op(4'h3, 16'h0001, 8'h00, 1'b0);
        $display("Test moves finished");
    endtask

    task automatic t_or();
        exec_op(4'h5, 16'h0020, 8'h00, 1'b0);
        exec_op(4'h6, 16'h0021, 8'h81, 1'b0);
        exec_op(4'h3, 16'h0022, 8'h0F, 1'b0);
        exec_op(4'h5, 16'h0023, 8'hF0, 1'b0);
        exec_op(4'h3, 16'h0024, 8'h00, 1'b0);
        exec_op(4'h6, 16'h0025, 8'h00, 1'b0);
        $display("Test logical or finished");
    endtask

    task automatic t_rotate();
        exec_op(4'h9, 16'h0030, 8'h80, 1'b0);
        exec_op(4'h7, 16'h0031, 8'h81, 1'b0);
        exec_op(4'h8, 16'h0032, 8'h80, 1'b0);
        exec_op(4'hB, 16'h0033, 8'h01, 1'b0);
        exec_op(4'hA, 16'h0034, 8'h40, 1'b0);
        exec_op(4'h9, 16'h0035, 8'h7F, 1'b0);
        exec_op(4'hB, 16'h0036, 8'h02, 1'b0);
        exec_op(4'hA, 16'h0037, 8'hFF, 1'b1);
        $display("Test rotates finished");
    endtask

    // Spare codes must finish like any other code yet change nothing.
    task automatic t_spare();
        for (int i = 12; i < 16; i++) begin
            exec_op(i[3:0], 16'h0040, 8'hFF, 1'b0);
        end
        $display("Test spare codes finished");
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        reset_i = 1'b1;
        start_i = 1'b0;
        op_i = edmalu_pkg::edmalu_op_t'(4'h0);
        addr_i = 16'h0000;
        mem_rdata_i = 8'hA5;
        error_cnt = 0;
        samples_checked = 0;
        do_reset();
        t_reset();
        t_inc_dec();
        t_move();
        t_or();
        t_rotate();
        t_spare();
        do_reset();
        t_reset();
        wrap_up();
    end

    // About 120 cycles are needed; 1000 leaves room without hiding a hang.
    initial begin
        #(50 * 1000);
        error_cnt++;
        $display("Error at %0t ns: watchdog expired", $time);
        wrap_up();
    end

endmodule
